// File: rtl/switch_unit_defs.vh
// constants for the switch unit position and command block
`ifndef SWITCH_UNIT_DEFS_VH
`define SWITCH_UNIT_DEFS_VH
`define OFS_CTRL 8'h00
`define OFS_CLOSE_LIMIT 8'h04
`define OFS_OPEN_LIMIT 8'h08
`define OFS_TRIP_MIN 8'h0C
`define OFS_CMD 8'h10
`define OFS_STATUS 8'h14
`define OFS_ROUTE 8'h18
`define CTRL_BREAK 0
`define CTRL_CONTROLLED 1
`define CTRL_LATCH 2
`define CTRL_INVISIBLE 3
`define CTRL_TYPE_LO 4
`define CTRL_TYPE_HI 5
`define CTRL_RESET 32'h0000_0003
`define TYPE_PLAIN 2'h0
`define TYPE_DISC_EARTH 2'h1
`define TYPE_EARTH_PART 2'h2
`define CMD_CLOSE 0
`define CMD_OPEN 1
`define CMD_FAIL_CLR 2
`define CMD_TRIP_ACK 3
`define POS_INTERMEDIATE 2'h0
`define POS_OPEN 2'h1
`define POS_CLOSED 2'h2
`define POS_DISTURBED 2'h3
`define CLOSE_LIMIT_MS 200
`define OPEN_LIMIT_MS 200
`define TRIP_MIN_MS 200
`define CLK_HZ 25000000
`define ROUTE_RESET 32'h0000_0000
`endif

// File: rtl/switch_unit.v
// position decode, travel supervision, interlocking and trip manager of one switch unit
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - closed contact true means closed
// - open contact true means open
// - earth contact true reports earthed
// - ready input shown and exported
// - removed input reports truck removed
// - separate close and open travel limits
// - any close block rejects close
// - any open block rejects open
// - trip request issues open command
// - trip held at least minimum time
// - latch setting keeps trip until acknowledged
// - trip release acknowledges and frees latch
// - trips only with break capability
// - close and open commands only when configured controlled; trip open, fail clear and trip ack work without it
// - relays driven by close and open drive, assignable by route, plus five other sources that are always on
// - external requests switch subject to interlocks
// - code 0 mid, 1 open, 2 closed, 3 disturbed
// - invisible unit monitored, no panel operation
// - disconnector-earthing: connected or earthed only
// - unit one defaults to break capability
`include "switch_unit_defs.vh"
module switch_unit #(
  parameter integer CLOSE_LIMIT_CYC = `CLOSE_LIMIT_MS * (`CLK_HZ / 1000),
  parameter integer OPEN_LIMIT_CYC = `OPEN_LIMIT_MS * (`CLK_HZ / 1000),
  parameter integer TRIP_MIN_CYC = `TRIP_MIN_MS * (`CLK_HZ / 1000),
  parameter integer TRIP_WIDTH = 4,
  parameter integer RELAYS = 2,
  parameter integer SOURCES = 7
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire closed_contact_input,
  input wire open_contact_input,
  input wire earth_contact_input,
  input wire ready_input,
  input wire removed_input,
  input wire [2:0] close_block_input,
  input wire [2:0] open_block_input,
  input wire [TRIP_WIDTH-1:0] trip_request_input,
  input wire trip_release,
  input wire ext_close_request,
  input wire ext_open_request,
  input wire panel_close_request,
  input wire panel_open_request,
  input wire [RELAYS*SOURCES-RELAYS*2-1:0] relay_other_sources,
  output reg [1:0] switch_state_code,
  output reg ready_to_reclose,
  output reg removed_flag,
  output reg close_drive_output,
  output reg open_drive_output,
  output reg trip_active,
  output reg supervision_fail,
  output reg [RELAYS-1:0] relay_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CLOSING = 3'b010;
  localparam ST_OPENING = 3'b100;
  localparam OTHERS = SOURCES - 2;

  reg [31:0] ctrl;
  reg [31:0] close_limit;
  reg [31:0] open_limit;
  reg [31:0] trip_min;
  reg [31:0] route;
  reg [2:0] state;
  reg [31:0] travel_cnt;
  reg [31:0] trip_cnt;
  reg trip_latched;
  reg sw_close;
  reg sw_open;
  reg sw_fail_clr;
  reg sw_ack;
  reg ph_write;
  reg [7:0] ph_addr;
  reg [1:0] next_code;
  reg [RELAYS-1:0] next_relay;
  integer i;
  integer j;

  wire break_cap = ctrl[`CTRL_BREAK];
  wire controlled = ctrl[`CTRL_CONTROLLED];
  wire [1:0] unit_type = ctrl[`CTRL_TYPE_HI:`CTRL_TYPE_LO];
  wire closed_c = closed_contact_input;
  wire open_c = open_contact_input;

  // decode shared by position logic and supervision
  function [1:0] pos_code;
    input c;
    input o;
    begin
      case ({c, o})
        2'b10: pos_code = `POS_CLOSED;
        2'b01: pos_code = `POS_OPEN;
        2'b11: pos_code = `POS_DISTURBED;
        default: pos_code = `POS_INTERMEDIATE;
      endcase
    end
  endfunction

  // one-step countdown shared by travel and trip timers
  function [31:0] count_down;
    input [31:0] v;
    begin
      count_down = v - 32'h0000_0001;
    end
  endfunction

  // the last count of a limit ends the move, so a limit of n allows n cycles
  function limit_hit;
    input [31:0] v;
    begin
      limit_hit = (v <= 32'h0000_0001);
    end
  endfunction

  // a request passes only while none of its block inputs is high
  function gate_req;
    input req;
    input [2:0] blocks;
    begin
      gate_req = req & ~(|blocks);
    end
  endfunction

  // panel requests are dropped for a unit hidden from the panel
  function panel_gate;
    input req;
    input hidden;
    begin
      panel_gate = req & ~hidden;
    end
  endfunction

  always @* begin
    case (unit_type)
      `TYPE_DISC_EARTH: next_code = pos_code(closed_c, earth_contact_input);
      `TYPE_EARTH_PART: next_code = pos_code(earth_contact_input, open_c);
      default: next_code = pos_code(closed_c, open_c);
    endcase
  end

  wire at_closed = (next_code == `POS_CLOSED);
  wire at_open = (next_code == `POS_OPEN);
  wire trip_any = |trip_request_input;
  // invisible unit ignores the panel
  wire panel_close = panel_gate(panel_close_request, ctrl[`CTRL_INVISIBLE]);
  wire panel_open = panel_gate(panel_open_request, ctrl[`CTRL_INVISIBLE]);
  wire close_req = controlled & (sw_close | ext_close_request | panel_close);
  wire open_req = controlled & (sw_open | ext_open_request | panel_open);
  wire close_ok = gate_req(close_req, close_block_input);
  wire open_ok = gate_req(open_req, open_block_input);
  // trip bypasses interlocks and needs break capability
  wire trip_now = break_cap & (trip_any | trip_latched | (trip_cnt != 32'h0000_0000));
  wire next_trip_latched = break_cap & ctrl[`CTRL_LATCH] & (trip_any | (trip_latched & ~trip_release & ~sw_ack));

  always @* begin
    for (i = 0; i < RELAYS; i = i + 1) begin
      next_relay[i] = 1'b0;
      if (route[2*i])
        next_relay[i] = next_relay[i] | close_drive_output;
      if (route[2*i+1])
        next_relay[i] = next_relay[i] | open_drive_output;
      for (j = 0; j < OTHERS; j = j + 1)
        next_relay[i] = next_relay[i] | relay_other_sources[i*OTHERS+j];
    end
  end

  // mirrored status lags the inputs by one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_state_code <= `POS_INTERMEDIATE;
      ready_to_reclose <= 1'b0;
      removed_flag <= 1'b0;
      relay_out <= {RELAYS{1'b0}};
    end else if (clk_en) begin
      switch_state_code <= next_code;
      ready_to_reclose <= ready_input;
      removed_flag <= removed_input;
      relay_out <= next_relay;
    end
  end

  // trip manager kept apart from the move machine so it can override any move
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_cnt <= 32'h0000_0000;
      trip_latched <= 1'b0;
      trip_active <= 1'b0;
    end else if (clk_en) begin
      trip_latched <= next_trip_latched;
      // every request cycle reloads, so the hold counts from the last one
      if (break_cap & trip_any)
        trip_cnt <= trip_min;
      else if (trip_cnt != 32'h0000_0000)
        trip_cnt <= count_down(trip_cnt);
      trip_active <= trip_now;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      travel_cnt <= 32'h0000_0000;
      close_drive_output <= 1'b0;
      open_drive_output <= 1'b0;
      supervision_fail <= 1'b0;
    end else if (clk_en) begin
      // failure set wins over clear
      if (sw_fail_clr)
        supervision_fail <= 1'b0;
      case (state)
        ST_IDLE: begin
          close_drive_output <= 1'b0;
          open_drive_output <= trip_now;
          if (trip_now) begin
            state <= ST_IDLE;
          end else if (open_ok & ~at_open) begin
            state <= ST_OPENING;
            travel_cnt <= open_limit;
            open_drive_output <= 1'b1;
          end else if (close_ok & ~at_closed) begin
            state <= ST_CLOSING;
            travel_cnt <= close_limit;
            close_drive_output <= 1'b1;
          end
        end
        ST_CLOSING: begin
          if (trip_now | at_closed) begin
            state <= ST_IDLE;
            close_drive_output <= 1'b0;
            open_drive_output <= trip_now;
          end else if (limit_hit(travel_cnt)) begin
            state <= ST_IDLE;
            close_drive_output <= 1'b0;
            supervision_fail <= 1'b1;
          end else begin
            travel_cnt <= count_down(travel_cnt);
          end
        end
        ST_OPENING: begin
          if (at_open & ~trip_now) begin
            state <= ST_IDLE;
            open_drive_output <= 1'b0;
          end else if (trip_now) begin
            state <= ST_IDLE;
          end else if (limit_hit(travel_cnt)) begin
            state <= ST_IDLE;
            open_drive_output <= 1'b0;
            supervision_fail <= 1'b1;
          end else begin
            travel_cnt <= count_down(travel_cnt);
          end
        end
        default: begin
          state <= ST_IDLE;
          close_drive_output <= 1'b0;
          open_drive_output <= 1'b0;
        end
      endcase
    end
  end

  // ahb-lite slave, zero wait states
  // only whole-word transfers are taken; narrower ones are ignored
  wire word_access = (hsize == 3'h2);
  wire ph_take = hsel & hready & htrans[1] & word_access;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CTRL_RESET;
      close_limit <= CLOSE_LIMIT_CYC;
      open_limit <= OPEN_LIMIT_CYC;
      trip_min <= TRIP_MIN_CYC;
      route <= `ROUTE_RESET;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      sw_close <= 1'b0;
      sw_open <= 1'b0;
      sw_fail_clr <= 1'b0;
      sw_ack <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      sw_close <= 1'b0;
      sw_open <= 1'b0;
      sw_fail_clr <= 1'b0;
      sw_ack <= 1'b0;
      ph_write <= ph_take & hwrite;
      if (ph_take)
        ph_addr <= haddr[7:0];
      if (ph_write) begin
        case (ph_addr)
          `OFS_CTRL: ctrl <= {26'h000_0000, hwdata[5:0]};
          `OFS_CLOSE_LIMIT: close_limit <= hwdata;
          `OFS_OPEN_LIMIT: open_limit <= hwdata;
          `OFS_TRIP_MIN: trip_min <= hwdata;
          `OFS_ROUTE: route <= hwdata;
          `OFS_CMD: begin
            sw_close <= hwdata[`CMD_CLOSE];
            sw_open <= hwdata[`CMD_OPEN];
            sw_fail_clr <= hwdata[`CMD_FAIL_CLR];
            sw_ack <= hwdata[`CMD_TRIP_ACK];
          end
          default: ;
        endcase
      end
    end
  end

  // read data is taken at the address phase so it stands through the data phase
  wire [31:0] status_word = {22'h00_0000, state, removed_flag, ready_to_reclose,
    supervision_fail, trip_active, trip_latched, switch_state_code};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (ph_take & ~hwrite) begin
        case (haddr[7:0])
          `OFS_CTRL: hrdata <= ctrl;
          `OFS_CLOSE_LIMIT: hrdata <= close_limit;
          `OFS_OPEN_LIMIT: hrdata <= open_limit;
          `OFS_TRIP_MIN: hrdata <= trip_min;
          `OFS_ROUTE: hrdata <= route;
          `OFS_STATUS: hrdata <= status_word;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// File: tb/switch_unit_chk.sv
// port assertions for the switch unit
`timescale 1ns/1ps
module switch_unit_chk #(
  parameter integer TRIP_WIDTH = 4,
  parameter integer CLOSE_LIMIT_CYC = 20,
  parameter integer TRIP_MIN_CYC = 20
) (
  input wire hclk,
  input wire hresetn,
  input wire closed_contact_input,
  input wire open_contact_input,
  input wire earth_contact_input,
  input wire ready_input,
  input wire removed_input,
  input wire [2:0] close_block_input,
  input wire [2:0] open_block_input,
  input wire [TRIP_WIDTH-1:0] trip_request_input,
  input wire [1:0] switch_state_code,
  input wire ready_to_reclose,
  input wire removed_flag,
  input wire close_drive_output,
  input wire open_drive_output,
  input wire trip_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // run length of one close move, for the travel bound
  reg [31:0] run = 32'h0000_0000;
  always @(posedge hclk) begin
    run <= close_drive_output ? run + 32'h0000_0001 : 32'h0000_0000;
  end
  // cycles since the last trip request, for the hold bound
  reg [31:0] since_req = 32'h0000_0000;
  always @(posedge hclk) begin
    since_req <= (|trip_request_input) ? 32'h0000_0000 : since_req + 32'h0000_0001;
  end
  // earth contact switches other unit types in, so plain decode is checked without it
  state_code_a: assert property ($past(hresetn) && !$past(earth_contact_input) |->
    switch_state_code == {$past(closed_contact_input), $past(open_contact_input)})
    else $error("position code wrong");
  ready_mirror_a: assert property ($past(hresetn) |->
    ready_to_reclose == $past(ready_input)) else $error("ready not mirrored");
  removed_mirror_a: assert property ($past(hresetn) |->
    removed_flag == $past(removed_input)) else $error("removed not mirrored");
  close_block_a: assert property ($rose(close_drive_output) |->
    $past(close_block_input) == 3'h0) else $error("close passed a block");
  open_block_a: assert property ($rose(open_drive_output) && !trip_active |->
    $past(open_block_input) == 3'h0) else $error("open passed a block");
  trip_drive_a: assert property (trip_active |-> open_drive_output)
    else $error("trip without open drive");
  trip_hold_a: assert property ($fell(trip_active) |->
    since_req >= TRIP_MIN_CYC) else $error("trip hold too short");
  close_travel_a: assert property (run <= CLOSE_LIMIT_CYC + 2)
    else $error("close drive outlived its limit");
endmodule
bind switch_unit switch_unit_chk #(.TRIP_WIDTH(TRIP_WIDTH),
  .CLOSE_LIMIT_CYC(CLOSE_LIMIT_CYC), .TRIP_MIN_CYC(TRIP_MIN_CYC)) u_chk (.hclk, .hresetn,
  .closed_contact_input, .open_contact_input, .earth_contact_input, .ready_input, .removed_input,
  .close_block_input, .open_block_input, .trip_request_input, .switch_state_code,
  .ready_to_reclose, .removed_flag, .close_drive_output, .open_drive_output, .trip_active);

// File: tb/gear_model.sv
// breaker contact model, travel of a few cycles or stuck
`timescale 1ns/1ps
module gear_model (
  input wire hclk,
  input wire cls,
  input wire opn,
  input wire stuck,
  output reg c_aux,
  output reg o_aux
);
  reg [3:0] n = 4'h0;
  initial begin
    c_aux = 1'b0;
    o_aux = 1'b1;
  end
  always @(posedge hclk) begin
    n <= (cls || opn) && !stuck ? n + 4'h1 : 4'h0;
    // both contacts off while the arm travels
    if (n == 4'h1) begin
      c_aux <= 1'b0;
      o_aux <= 1'b0;
    end
    if (n == 4'h4) begin
      c_aux <= cls;
      o_aux <= opn;
    end
  end
endmodule

// File: tb/test_switch_unit.sv
// self-checking bench for the switch unit
`timescale 1ns/1ps
`include "switch_unit_defs.vh"
module test_switch_unit;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, trip_release = 1'b0;
  reg ready_input = 1'b0, removed_input = 1'b0, ext_close_request = 1'b0;
  reg earth_contact_input = 1'b0, panel_close_request = 1'b0, panel_open_request = 1'b0;
  reg ext_open_request = 1'b0, c_ovr = 1'b0, cv = 1'b0, ov = 1'b0, stuck = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] close_block_input = 3'h0, open_block_input = 3'h0;
  reg [3:0] trip_request_input = 4'h0;
  reg [9:0] relay_other_sources = 10'h000;
  reg [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  wire [31:0] hrdata;
  wire [1:0] switch_state_code, relay_out;
  wire hreadyout, ready_to_reclose, removed_flag, close_drive_output, open_drive_output;
  wire trip_active, supervision_fail, c_aux, o_aux, hresp;
  int miscompares = 0, cmp_count = 0;
  switch_unit #(.CLOSE_LIMIT_CYC(20), .OPEN_LIMIT_CYC(20), .TRIP_MIN_CYC(20)) u_dut (
    .hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .closed_contact_input(c_ovr ? cv : c_aux), .open_contact_input(c_ovr ? ov : o_aux),
    .earth_contact_input, .ready_input, .removed_input, .close_block_input,
    .open_block_input, .trip_request_input, .trip_release, .ext_close_request,
    .ext_open_request, .panel_close_request, .panel_open_request,
    .relay_other_sources, .switch_state_code, .ready_to_reclose, .removed_flag,
    .close_drive_output, .open_drive_output, .trip_active, .supervision_fail, .relay_out);
  gear_model u_gear (.hclk, .cls(close_drive_output), .opn(open_drive_output), .stuck,
    .c_aux, .o_aux);
  initial begin
    forever #20 hclk = ~hclk;
  end
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // zero-wait slave, but the wait stays bounded anyway
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      complete_run;
    end
  endtask
  task automatic bus(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input [7:0] a, input [31:0] e);
    reg [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
    chk(32'(hresp), 0);
  endtask
  task automatic t_reset;
    rd(`OFS_CTRL, `CTRL_RESET);
    rd(`OFS_OPEN_LIMIT, 32'h0000_0014);
    rd(8'h1C, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task automatic t_decode;
    c_ovr <= 1'b1;
    ready_input <= 1'b1;
    removed_input <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      {cv, ov} <= k[1:0];
      cyc(3);
      chk(32'(switch_state_code), k);
    end
    chk(32'(ready_to_reclose), 1);
    chk(32'(removed_flag), 1);
    c_ovr <= 1'b0;
    relay_other_sources <= 10'h001;
    cyc(3);
    chk(32'(relay_out[0]), 1);
    relay_other_sources <= 10'h000;
    $display("t_decode done");
  endtask
  task automatic t_close;
    close_block_input <= 3'h4;
    ext_close_request <= 1'b1;
    cyc(6);
    chk(32'(close_drive_output), 0);
    close_block_input <= 3'h0;
    cyc(3);
    chk(32'(close_drive_output), 1);
    ext_close_request <= 1'b0;
    cyc(10);
    chk(32'(close_drive_output), 0);
    chk(32'(switch_state_code), 2);
    $display("t_close done");
  endtask
  task automatic t_open;
    wr(`OFS_ROUTE, 32'h0000_0002);
    open_block_input <= 3'h1;
    ext_open_request <= 1'b1;
    cyc(6);
    chk(32'(open_drive_output), 0);
    stuck <= 1'b1;
    open_block_input <= 3'h0;
    cyc(3);
    chk(32'(open_drive_output), 1);
    chk(32'(relay_out[0]), 1);
    ext_open_request <= 1'b0;
    cyc(25);
    chk(32'(open_drive_output), 0);
    chk(32'(supervision_fail), 1);
    stuck <= 1'b0;
    wr(`OFS_CMD, 32'h0000_0004);
    cyc(2);
    chk(32'(supervision_fail), 0);
    $display("t_open done");
  endtask
  task automatic t_trip;
    wr(`OFS_CTRL, 32'h0000_0007);
    trip_request_input <= 4'h2;
    cyc(1);
    trip_request_input <= 4'h0;
    cyc(2);
    chk(32'(open_drive_output), 1);
    cyc(25);
    chk(32'(trip_active), 1);
    trip_release <= 1'b1;
    cyc(1);
    trip_release <= 1'b0;
    cyc(25);
    chk(32'(trip_active), 0);
    wr(`OFS_CTRL, 32'h0000_0003);
    trip_request_input <= 4'h8;
    cyc(1);
    trip_request_input <= 4'h0;
    cyc(15);
    chk(32'(trip_active), 1);
    cyc(15);
    chk(32'(trip_active), 0);
    $display("t_trip done");
  endtask
  task automatic t_config;
    wr(`OFS_CTRL, 32'h0000_0002);
    trip_request_input <= 4'h1;
    cyc(4);
    chk(32'(trip_active), 0);
    trip_request_input <= 4'h0;
    wr(`OFS_CTRL, 32'h0000_0001);
    ext_close_request <= 1'b1;
    cyc(6);
    chk(32'(close_drive_output), 0);
    ext_close_request <= 1'b0;
    $display("t_config done");
  endtask
  task automatic t_panel;
    wr(`OFS_CTRL, 32'h0000_000B);
    panel_close_request <= 1'b1;
    cyc(6);
    chk(32'(close_drive_output), 0);
    wr(`OFS_CTRL, 32'h0000_0003);
    cyc(3);
    chk(32'(close_drive_output), 1);
    panel_close_request <= 1'b0;
    cyc(10);
    panel_open_request <= 1'b1;
    cyc(3);
    chk(32'(open_drive_output), 1);
    panel_open_request <= 1'b0;
    cyc(10);
    $display("t_panel done");
  endtask
  task automatic t_earth;
    c_ovr <= 1'b1;
    {cv, ov} <= 2'h0;
    earth_contact_input <= 1'b1;
    cyc(2);
    wr(`OFS_CTRL, 32'h0000_0023);
    cyc(3);
    chk(32'(switch_state_code), 2);
    wr(`OFS_CTRL, 32'h0000_0013);
    cyc(3);
    chk(32'(switch_state_code), 1);
    wr(`OFS_CTRL, 32'h0000_0003);
    earth_contact_input <= 1'b0;
    cyc(3);
    c_ovr <= 1'b0;
    cyc(2);
    $display("t_earth done");
  endtask
  initial begin
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    t_reset;
    t_decode;
    t_close;
    t_open;
    t_trip;
    t_config;
    t_panel;
    t_earth;
    complete_run;
  end
endmodule
